// File: core/amp_map.svh
// register offsets, field positions, reset values and timing constants of the amplifier control bank
// Overview of operation
// - four 2-bit state requests, each resetting to 01
// - request codes: playing_state, high impedance, mute, diagnostics
// - four 8-bit volume registers at 0x05-0x08, reset 0xCF
// - volume in half-dB steps, codes below 0x07 mute
// - writing abort 1 stops a running diagnostic
// - doubled bits double ramp and settle times
// - line-output check runs only when enabled
// - skip 0: auto run leaving high impedance, fault
// - skip bit 1: run only on written request 11
// - 4-bit shorted-load threshold per channel, reset 0001
// - 0x0A holds channel 1 and 2 thresholds
// - 0x0B holds channel 3 and 4 thresholds
// - 0x0C read-only report, channels 1 and 2
// - ground short flag set when detected
// - supply short flag set when detected
// - open load flag set when no load
// - shorted-load flag set when load below threshold, threshold codes above 9 taken as 9
// - 0x0D read-only report, channels 3 and 4
// - read-only state report shows actual channel states
`ifndef AMP_MAP_SVH
`define AMP_MAP_SVH
`define AMP_OFS_STATE     8'h04
`define AMP_OFS_VOL_BASE  8'h05
`define AMP_OFS_VOL_LAST  8'h08
`define AMP_OFS_CTL       8'h09
`define AMP_OFS_THR12     8'h0A
`define AMP_OFS_THR34     8'h0B
`define AMP_OFS_RPT12     8'h0C
`define AMP_OFS_RPT34     8'h0D
`define AMP_OFS_STREP     8'h0F
`define AMP_RST_STATE     8'h55
`define AMP_RST_VOL       8'hCF
`define AMP_RST_CTL       8'h00
`define AMP_RST_THR       8'h11
`define AMP_RST_RPT       8'h00
`define AMP_CTL_ABORT     7
`define AMP_CTL_DRAMP     6
`define AMP_CTL_DSETTLE   5
`define AMP_CTL_LINE      1
`define AMP_CTL_SKIP      0
`define AMP_CTL_WMASK     8'hE3
`define AMP_CTL_RSVD      4:2
`define AMP_VOL_MUTE_BELOW 8'h07
`define AMP_THR_MAX       4'h9
`define AMP_BYTE_BITS     4'h8
`define AMP_LAST_BIT      4'h7
`define AMP_DEV_ADDR      7'h2A
`define AMP_CLK_NS        40
`define AMP_RAMP_NS       10000
`define AMP_SETTLE_NS     20000
`define AMP_LINE_NS       5000
`endif

// File: core/amp_pkg.sv
// types shared by the amplifier control bank
package amp_pkg;
	typedef enum logic [1:0] {
		CH_PLAYING_STATE        = 2'h0,
		CH_HIGH_IMPEDANCE_STATE = 2'h1,
		CH_MUTE_STATE           = 2'h2,
		CH_DIAG_STATE           = 2'h3
	} amp_chst_type;
	typedef struct packed {
		logic ground_short_flag;
		logic supply_short_flag;
		logic open_load_flag;
		logic line_seen;
	} amp_sense_type;
	typedef struct packed {
		logic       en;
		logic [7:0] addr;
		logic [7:0] data;
	} amp_wr_type;
	typedef enum logic [8:0] {
		BUS_IDLE  = 9'h001,
		BUS_ADDR  = 9'h002,
		BUS_AACK  = 9'h004,
		BUS_PTR   = 9'h008,
		BUS_PACK  = 9'h010,
		BUS_WDATA = 9'h020,
		BUS_WACK  = 9'h040,
		BUS_RDATA = 9'h080,
		BUS_RACK  = 9'h100
	} amp_bus_type;
	typedef enum logic [4:0] {
		SEQ_IDLE   = 5'h01,
		SEQ_RAMP   = 5'h02,
		SEQ_SETTLE = 5'h04,
		SEQ_LINE   = 5'h08,
		SEQ_MEAS   = 5'h10
	} amp_seq_type;
endpackage

// File: core/amp_regs.sv
// control register bank with serial control slave and load-diagnostic sequencer
`timescale 1ns/1ns
`include "amp_map.svh"
module amp_regs #(
	parameter logic [6:0] DEV_ADDR  = `AMP_DEV_ADDR,
	parameter int         RAMP_NS   = `AMP_RAMP_NS,
	parameter int         SETTLE_NS = `AMP_SETTLE_NS,
	parameter int         LINE_NS   = `AMP_LINE_NS
) (
	input  wire logic                     sys_clk,
	input  wire logic                     rst_b,
	input  wire logic                     scl_in,
	input  wire logic                     sda_in,
	output logic                          sda_oe_b,
	input  wire amp_pkg::amp_sense_type [0:3] ch_sense,
	input  wire logic [0:3][3:0]          ch_load_code,
	input  wire logic [0:3]               ch_fault,
	output logic [7:0]                    ch_state,
	output logic [31:0]                   ch_gain,
	output logic [3:0]                    ch_muted,
	output logic                          diag_ramp,
	output logic                          diag_settle,
	output logic                          diag_line
);
	import amp_pkg::*;

	localparam int SW = 38;
	localparam logic [SW-1:0] SYNC_RST = {2'h3, 36'h0};
	// least times round up to whole cycles
	localparam int RAMP_CYC   = (RAMP_NS + `AMP_CLK_NS - 1) / `AMP_CLK_NS;
	localparam int SETTLE_CYC = (SETTLE_NS + `AMP_CLK_NS - 1) / `AMP_CLK_NS;
	localparam int LINE_CYC   = (LINE_NS + `AMP_CLK_NS - 1) / `AMP_CLK_NS;

	logic [1:0]          rst_sq;
	logic                rst_sync_b;
	logic [SW-1:0]       s1_q, s2_q, s3_q, stab_q, stab_d;
	logic                scl_s, sda_s, scl_prev_q, sda_prev_q;
	logic                scl_rise, scl_fall, start_c, stop_c, rx_state, byte_done;
	amp_sense_type [0:3] sense_s;
	logic [0:3][3:0]     load_s;
	logic [0:3]          fault_s, fault_prev_q, fault_rise;
	amp_bus_type         bus_q;
	logic [3:0]          bit_q;
	logic [7:0]          sh_q, ptr_q, rd_data;
	logic                rw_q, nack_q, oe_b_q;
	amp_wr_type          wr_q;
	logic                we_state, we_ctl, we_thr12, we_thr34;
	logic [0:3]          we_vol;
	logic [0:3][1:0]     req_q, req_prev_q;
	logic [0:3][7:0]     vol_q;
	logic [7:0]          ctl_q;
	logic [0:3][3:0]     thr_q, thr_eff, rpt_q, rpt_d;
	amp_chst_type [0:3]  st_q, st_d;
	logic [0:3]          pend_q, pend_d, mask_q, set_ev, muted_q;
	amp_seq_type         seq_q, seq_d;
	logic [15:0]         tmr_q, tmr_d, ramp_load, settle_load, line_load;
	logic                abort, skip, line_en, run, start, meas, is_vol;
	logic [1:0]          vol_idx;

	// reset release through two flops
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) rst_sq <= 2'h0;
		else rst_sq <= {rst_sq[0], 1'b1};
	end
	assign rst_sync_b = rst_sq[1];

	// outside inputs: three flops, a change counts once stages two and three agree
	always_ff @(posedge sys_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			s1_q   <= SYNC_RST;
			s2_q   <= SYNC_RST;
			s3_q   <= SYNC_RST;
			stab_q <= SYNC_RST;
		end else begin
			s1_q   <= {scl_in, sda_in, ch_sense, ch_load_code, ch_fault};
			s2_q   <= s1_q;
			s3_q   <= s2_q;
			stab_q <= stab_d;
		end
	end
	assign stab_d  = (s2_q & ~(s2_q ^ s3_q)) | (stab_q & (s2_q ^ s3_q));
	assign scl_s   = stab_q[37];
	assign sda_s   = stab_q[36];
	assign sense_s = stab_q[35:20];
	assign load_s  = stab_q[19:4];
	assign fault_s = stab_q[3:0];

	// bus edges and framing conditions
	assign scl_rise  = scl_s & ~scl_prev_q;
	assign scl_fall  = ~scl_s & scl_prev_q;
	assign start_c   = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
	assign stop_c    = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
	assign rx_state  = (bus_q == BUS_ADDR) | (bus_q == BUS_PTR) | (bus_q == BUS_WDATA);
	assign byte_done = scl_fall & (bit_q == `AMP_BYTE_BITS);

	// serial slave: address, register pointer, data with pointer auto-increment
	always_ff @(posedge sys_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
			bus_q      <= BUS_IDLE;
			bit_q      <= 4'h0;
			sh_q       <= 8'h00;
			ptr_q      <= 8'h00;
			rw_q       <= 1'b0;
			nack_q     <= 1'b1;
			oe_b_q     <= 1'b1;
			wr_q       <= '0;
		end else begin
			scl_prev_q <= scl_s;
			sda_prev_q <= sda_s;
			wr_q.en    <= 1'b0;
			if (rx_state && scl_rise) begin
				sh_q  <= {sh_q[6:0], sda_s};
				bit_q <= bit_q + 4'h1;
			end
			// a start anywhere restarts framing, which also serves repeated start
			if (start_c) begin
				bus_q  <= BUS_ADDR;
				bit_q  <= 4'h0;
				oe_b_q <= 1'b1;
			end else if (stop_c) begin
				bus_q  <= BUS_IDLE;
				oe_b_q <= 1'b1;
			end else begin
				unique case (bus_q)
					BUS_IDLE: begin
					end
					BUS_ADDR: if (byte_done) begin
						bit_q <= 4'h0;
						// other addresses are left alone, line stays released
						if (sh_q[7:1] == DEV_ADDR) begin
							rw_q   <= sh_q[0];
							oe_b_q <= 1'b0;
							bus_q  <= BUS_AACK;
						end else begin
							bus_q <= BUS_IDLE;
						end
					end
					BUS_PTR: if (byte_done) begin
						bit_q  <= 4'h0;
						ptr_q  <= sh_q;
						oe_b_q <= 1'b0;
						bus_q  <= BUS_PACK;
					end
					BUS_WDATA: if (byte_done) begin
						bit_q  <= 4'h0;
						wr_q   <= '{en: 1'b1, addr: ptr_q, data: sh_q};
						ptr_q  <= ptr_q + 8'h01;
						oe_b_q <= 1'b0;
						bus_q  <= BUS_WACK;
					end
					BUS_AACK, BUS_RACK: begin
						if (scl_rise) nack_q <= sda_s;
						if (scl_fall) begin
							if ((bus_q == BUS_AACK && rw_q) || (bus_q == BUS_RACK && !nack_q)) begin
								sh_q   <= rd_data;
								oe_b_q <= rd_data[7];
								ptr_q  <= ptr_q + 8'h01;
								bus_q  <= BUS_RDATA;
							end else begin
								oe_b_q <= 1'b1;
								bus_q  <= (bus_q == BUS_AACK) ? BUS_PTR : BUS_IDLE;
							end
						end
					end
					BUS_PACK, BUS_WACK: if (scl_fall) begin
						oe_b_q <= 1'b1;
						bus_q  <= BUS_WDATA;
					end
					BUS_RDATA: if (scl_fall) begin
						if (bit_q == `AMP_LAST_BIT) begin
							bit_q  <= 4'h0;
							oe_b_q <= 1'b1;
							nack_q <= 1'b1;
							bus_q  <= BUS_RACK;
						end else begin
							bit_q  <= bit_q + 4'h1;
							sh_q   <= {sh_q[6:0], 1'b0};
							oe_b_q <= sh_q[6];
						end
					end
				endcase
			end
		end
	end

	// write decode; unmapped offsets are dropped
	assign we_state = wr_q.en & (wr_q.addr == `AMP_OFS_STATE);
	assign we_ctl   = wr_q.en & (wr_q.addr == `AMP_OFS_CTL);
	assign we_thr12 = wr_q.en & (wr_q.addr == `AMP_OFS_THR12);
	assign we_thr34 = wr_q.en & (wr_q.addr == `AMP_OFS_THR34);
	for (genvar i = 0; i < 4; i++) begin : g_wv
		assign we_vol[i] = wr_q.en & (wr_q.addr == `AMP_OFS_VOL_BASE + 8'(i));
	end

	// read selection; unmapped offsets read zero
	assign is_vol  = (ptr_q >= `AMP_OFS_VOL_BASE) && (ptr_q <= `AMP_OFS_VOL_LAST);
	assign vol_idx = 2'(ptr_q - `AMP_OFS_VOL_BASE);
	assign rd_data = (ptr_q == `AMP_OFS_STATE) ? req_q :
		is_vol ? vol_q[vol_idx] :
		(ptr_q == `AMP_OFS_CTL) ? ctl_q :
		(ptr_q == `AMP_OFS_THR12) ? {thr_q[0], thr_q[1]} :
		(ptr_q == `AMP_OFS_THR34) ? {thr_q[2], thr_q[3]} :
		(ptr_q == `AMP_OFS_RPT12) ? {rpt_q[0], rpt_q[1]} :
		(ptr_q == `AMP_OFS_RPT34) ? {rpt_q[2], rpt_q[3]} :
		(ptr_q == `AMP_OFS_STREP) ? st_q : 8'h00;

	// host-written registers
	always_ff @(posedge sys_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			req_q <= `AMP_RST_STATE;
			vol_q <= {4{`AMP_RST_VOL}};
			ctl_q <= `AMP_RST_CTL;
			thr_q <= {2{`AMP_RST_THR}};
		end else begin
			if (we_state) req_q <= wr_q.data;
			for (int i = 0; i < 4; i++) begin
				if (we_vol[i]) vol_q[i] <= wr_q.data;
			end
			if (we_ctl) ctl_q <= wr_q.data & `AMP_CTL_WMASK;
			if (we_thr12) thr_q[0:1] <= wr_q.data;
			if (we_thr34) thr_q[2:3] <= wr_q.data;
		end
	end

	// diagnostic controls and phase lengths
	assign abort       = ctl_q[`AMP_CTL_ABORT];
	assign skip        = ctl_q[`AMP_CTL_SKIP];
	assign line_en     = ctl_q[`AMP_CTL_LINE];
	assign run         = seq_q != SEQ_IDLE;
	assign meas        = seq_q == SEQ_MEAS;
	// abort held high blocks new runs until the host clears it
	assign start       = (seq_q == SEQ_IDLE) & (|pend_q) & ~abort;
	assign ramp_load   = 16'(ctl_q[`AMP_CTL_DRAMP] ? 2 * RAMP_CYC - 1 : RAMP_CYC - 1);
	assign settle_load = 16'(ctl_q[`AMP_CTL_DSETTLE] ? 2 * SETTLE_CYC - 1 : SETTLE_CYC - 1);
	assign line_load   = 16'(LINE_CYC - 1);

	// sequencer: ramp, settle, optional line check, one measure cycle
	always_comb begin
		seq_d = seq_q;
		tmr_d = (tmr_q == 16'h0000) ? tmr_q : tmr_q - 16'h0001;
		if (abort && run) begin
			seq_d = SEQ_IDLE;
		end else begin
			unique case (seq_q)
				SEQ_IDLE: if (start) begin
					seq_d = SEQ_RAMP;
					tmr_d = ramp_load;
				end
				SEQ_RAMP: if (tmr_q == 16'h0000) begin
					seq_d = SEQ_SETTLE;
					tmr_d = settle_load;
				end
				SEQ_SETTLE: if (tmr_q == 16'h0000) begin
					if (line_en) begin
						seq_d = SEQ_LINE;
						tmr_d = line_load;
					end else begin
						seq_d = SEQ_MEAS;
					end
				end
				SEQ_LINE: if (tmr_q == 16'h0000) seq_d = SEQ_MEAS;
				SEQ_MEAS: seq_d = SEQ_IDLE;
			endcase
		end
	end

	// per-channel triggers, results and actual state
	for (genvar i = 0; i < 4; i++) begin : g_ch
		assign fault_rise[i] = fault_s[i] & ~fault_prev_q[i];
		// new request is taken as written; explicit 11 always runs, automatic runs only without skip
		assign set_ev[i] = (we_state && wr_q.data[7-2*i -: 2] == CH_DIAG_STATE) |
			(~skip & ((req_prev_q[i] == CH_HIGH_IMPEDANCE_STATE && req_q[i] != CH_HIGH_IMPEDANCE_STATE)
			| fault_rise[i]));
		// a new trigger wins over the clear by start or abort
		assign pend_d[i] = set_ev[i] | (pend_q[i] & ~start & ~abort);
		assign thr_eff[i] = (thr_q[i] > `AMP_THR_MAX) ? `AMP_THR_MAX : thr_q[i];
		assign rpt_d[i] = (start & pend_q[i]) ? 4'h0 :
			(meas & mask_q[i]) ? {sense_s[i].ground_short_flag,
				sense_s[i].supply_short_flag,
				sense_s[i].open_load_flag & ~(line_en & sense_s[i].line_seen),
				load_s[i] < thr_eff[i]} : rpt_q[i];
		// waiting channels hold their state; a finished explicit run parks in high impedance
		assign st_d[i] = (run & mask_q[i]) ? CH_DIAG_STATE :
			(pend_q[i] | pend_d[i]) ? st_q[i] :
			(req_q[i] != CH_DIAG_STATE) ? amp_chst_type'(req_q[i]) :
			(st_q[i] == CH_DIAG_STATE) ? CH_HIGH_IMPEDANCE_STATE : st_q[i];
	end

	// sequencer and channel state registers
	always_ff @(posedge sys_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			seq_q        <= SEQ_IDLE;
			tmr_q        <= 16'h0000;
			pend_q       <= 4'h0;
			mask_q       <= 4'h0;
			rpt_q        <= {2{`AMP_RST_RPT}};
			st_q         <= {4{CH_HIGH_IMPEDANCE_STATE}};
			req_prev_q   <= `AMP_RST_STATE;
			fault_prev_q <= 4'h0;
			muted_q      <= 4'h0;
		end else begin
			seq_q        <= seq_d;
			tmr_q        <= tmr_d;
			pend_q       <= pend_d;
			if (start) mask_q <= pend_q;
			rpt_q        <= rpt_d;
			st_q         <= st_d;
			req_prev_q   <= req_q;
			fault_prev_q <= fault_s;
			for (int i = 0; i < 4; i++) begin
				muted_q[i] <= (vol_q[i] < `AMP_VOL_MUTE_BELOW) | (st_q[i] == CH_MUTE_STATE);
			end
		end
	end

	// outputs from flops; the phase outputs are decoded from seq_q
	assign sda_oe_b    = oe_b_q;
	assign ch_state    = st_q;
	assign ch_gain     = vol_q;
	assign ch_muted    = muted_q;
	assign diag_ramp   = seq_q == SEQ_RAMP;
	assign diag_settle = seq_q == SEQ_SETTLE;
	assign diag_line   = seq_q == SEQ_LINE;

	// checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_sync_b);
	logic [15:0] ramp_cnt_q;
	always_ff @(posedge sys_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) ramp_cnt_q <= 16'h0000;
		else ramp_cnt_q <= (seq_q == SEQ_RAMP) ? ramp_cnt_q + 16'h0001 : 16'h0000;
	end
	AST_ABORT_STOPS: assert property (abort && run |=> seq_q == SEQ_IDLE)
		else $error("abort did not stop the diagnostic run");
	AST_ABORT_BLOCKS: assert property (abort |=> !run)
		else $error("diagnostic running while abort set");
	AST_RAMP_LEN: assert property ($fell(seq_q == SEQ_RAMP) && !$past(abort)
		|-> ramp_cnt_q == 16'($past(ctl_q[`AMP_CTL_DRAMP]) ? 2 * RAMP_CYC : RAMP_CYC))
		else $error("ramp length wrong");
	AST_LINE_SKIP: assert property ($rose(seq_q == SEQ_LINE) |-> $past(line_en))
		else $error("line check ran while disabled");
	AST_BYPASS: assert property (skip && !we_state && pend_q == 4'h0 |=> pend_q == 4'h0)
		else $error("diagnostic started without a trigger");
	AST_AUTO: assert property (!skip && req_prev_q[0] == CH_HIGH_IMPEDANCE_STATE
		&& req_q[0] == CH_PLAYING_STATE |=> pend_q[0] || run)
		else $error("no automatic run on leaving high impedance");
	AST_RSVD_ZERO: assert property (ctl_q[`AMP_CTL_RSVD] == 3'h0)
		else $error("reserved control bits set");
	AST_MUTE_FLOOR: assert property (vol_q[1] < `AMP_VOL_MUTE_BELOW ##1 vol_q[1] < `AMP_VOL_MUTE_BELOW
		|-> muted_q[1])
		else $error("low volume code did not mute");
	AST_SHORT_FLAG: assert property (meas && mask_q[1] |=> rpt_q[1][0] == ($past(load_s[1]) < $past(thr_eff[1])))
		else $error("shorted-load flag mismatch");
	AST_DIAG_STATE: assert property ($rose(st_q[0] == CH_DIAG_STATE) |-> $past(run && mask_q[0]))
		else $error("diagnostic state shown without a run");
endmodule

// File: tb/amp_host.sv
// two-wire control host model for the amplifier register bank
`timescale 1ns/1ns
`include "amp_map.svh"
module amp_host #(
	parameter int HALF = 10
) (
	input  wire logic  sys_clk,
	input  wire logic  sda_line,
	output logic       scl_out,
	output logic       sda_rel,
	output logic       rd_done,
	output logic [7:0] rd_data,
	output int         nack_count
);
	logic [7:0] q;
	logic       a;
	// bus idles high; the clock only moves inside transfers
	initial begin
		scl_out = 1'b1;
		sda_rel = 1'b1;
		rd_done = 1'b0;
		rd_data = 8'h00;
		nack_count = 0;
	end
	// every change lands on a falling edge of the device clock
	task automatic wt(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	// data moves one cycle after scl falls so it never races the clock
	task automatic bitx(input logic b, output logic s);
		wt(1);
		sda_rel = b;
		wt(HALF);
		scl_out = 1'b1;
		wt(HALF / 2);
		s = sda_line;
		wt(HALF / 2);
		scl_out = 1'b0;
	endtask
	task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] r, output logic k);
		for (int i = 7; i >= 0; i--)
			bitx(d[i], r[i]);
		bitx(last, k);
	endtask
	// start and repeated start alike: raise both lines, then drop data
	task automatic start();
		wt(1);
		sda_rel = 1'b1;
		wt(HALF);
		scl_out = 1'b1;
		wt(HALF);
		sda_rel = 1'b0;
		wt(HALF);
		scl_out = 1'b0;
	endtask
	task automatic stop();
		wt(1);
		sda_rel = 1'b0;
		wt(HALF);
		scl_out = 1'b1;
		wt(HALF);
		sda_rel = 1'b1;
		wt(HALF);
	endtask
	// a byte the device must acknowledge; a missing ack is counted
	task automatic sendb(input logic [7:0] d);
		xfer(d, 1'b1, q, a);
		if (a !== 1'b0)
			nack_count++;
	endtask
	task automatic wr_reg(input logic [7:0] p, input logic [7:0] d);
		start();
		sendb({`AMP_DEV_ADDR, 1'b0});
		sendb(p);
		sendb(d);
		stop();
	endtask
	task automatic rd_reg(input logic [7:0] p);
		start();
		sendb({`AMP_DEV_ADDR, 1'b0});
		sendb(p);
		start();
		sendb({`AMP_DEV_ADDR, 1'b1});
		xfer(8'hFF, 1'b1, q, a);
		stop();
		rd_data = q;
		rd_done = 1'b1;
		wt(1);
		rd_done = 1'b0;
	endtask
endmodule

// File: tb/test_amp_regs.sv
// self-checking bench for the amplifier control register bank
`timescale 1ns/1ns
`include "amp_map.svh"
module test_amp_regs;
	import amp_pkg::*;
	localparam int RCYC = 1000;
	localparam int SCYC = 10;
	localparam int LCYC = 10;
	localparam logic [7:0] RST_IMG [0:11] = '{8'h55, 8'hCF, 8'hCF, 8'hCF, 8'hCF, 8'h00,
		8'h11, 8'h11, 8'h00, 8'h00, 8'h00, 8'h55};
	logic                sys_clk = 1'b0;
	logic                ramp_prev = 1'b0;
	logic                rst_b = 1'b0;
	wire logic           scl;
	wire logic           sda_rel;
	wire logic           sda_oe_b;
	wire logic           sda_line;
	wire logic           rd_done;
	wire logic [7:0]     rd_data;
	int                  nack_count;
	amp_sense_type [0:3] sense;
	logic [0:3][3:0]     load;
	logic [0:3]          fault;
	wire logic [7:0]     ch_state;
	wire logic [31:0]    ch_gain;
	wire logic [3:0]     ch_muted;
	wire logic           diag_ramp;
	wire logic           diag_settle;
	wire logic           diag_line;
	logic [7:0]          exp_q [$];
	logic [31:0]         seed = 32'h0000C2D3;
	logic [7:0]          v;
	int                  err_count = 0;
	int                  checks_done = 0;
	int                  ramp_n = 0;
	int                  settle_n = 0;
	int                  line_n = 0;
	int                  runs = 0;
	int                  r0, s0, l0, n0;

	always #20 sys_clk = ~sys_clk;
	// pulled-up data wire: low while either side pulls it
	assign sda_line = sda_oe_b & sda_rel;

	amp_regs #(.RAMP_NS(40000), .SETTLE_NS(400), .LINE_NS(400)) amp_regs_i (.sys_clk, .rst_b,
		.scl_in(scl), .sda_in(sda_line), .sda_oe_b, .ch_sense(sense), .ch_load_code(load),
		.ch_fault(fault), .ch_state, .ch_gain, .ch_muted, .diag_ramp, .diag_settle, .diag_line);
	amp_host amp_host_i (.sys_clk, .sda_line, .scl_out(scl), .sda_rel, .rd_done, .rd_data,
		.nack_count);

	// phase lengths and run starts, seen only at the sequencer outputs
	always @(posedge sys_clk) begin
		if (diag_ramp === 1'b1)
			ramp_n <= ramp_n + 1;
		if (diag_settle === 1'b1)
			settle_n <= settle_n + 1;
		if (diag_line === 1'b1)
			line_n <= line_n + 1;
		if (diag_ramp === 1'b1 && ramp_prev !== 1'b1)
			runs <= runs + 1;
		ramp_prev <= diag_ramp;
	end
	// each finished read is matched against the oldest note
	always @(posedge sys_clk)
		if (rd_done === 1'b1)
			check_byte(exp_q.pop_front(), rd_data);

	task automatic bad(input logic [31:0] e, input logic [31:0] g);
		err_count++;
		$display("wrong value at %0t: got %h expected %h", $time, g, e);
	endtask
	task automatic check_byte(input logic [7:0] e, input logic [7:0] g);
		checks_done++;
		if (g !== e)
			bad({24'h0, e}, {24'h0, g});
	endtask
	task automatic check_port(input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e)
			bad(e, g);
	endtask
	task automatic rd_check(input logic [7:0] p, input logic [7:0] e);
		exp_q.push_back(e);
		amp_host_i.rd_reg(p);
	endtask
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	task automatic snap();
		r0 = ramp_n;
		s0 = settle_n;
		l0 = line_n;
		n0 = runs;
	endtask
	// a run is over once every phase output has stayed low a few cycles
	task automatic wait_idle();
		int k;
		k = 0;
		for (int i = 0; i < 6000; i++) begin
			@(negedge sys_clk);
			k = ({diag_ramp, diag_settle, diag_line} === 3'b000) ? k + 1 : 0;
			if (k == 4)
				return;
		end
		err_count++;
	endtask
	task automatic conclude();
		if (err_count == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial begin
		#3500000;
		err_count++;
		conclude();
	end

	initial begin
		sense = {4'hA, 4'h7, 4'h0, 4'h0};
		load = {4'h9, 4'h3, 4'h0, 4'h0};
		fault = 4'h0;
		repeat (6) @(negedge sys_clk);
		rst_b = 1'b1;
		repeat (10) @(negedge sys_clk);
		// reset image of the map, hole at 0x0E included
		check_port(32'hCFCFCFCF, ch_gain);
		check_port(32'h00000055, {24'h0, ch_state});
		for (int a = 4; a < 16; a++)
			rd_check(8'(a), RST_IMG[a - 4]);
		// random volumes, with the mute floor and its boundary forced
		for (int c = 0; c < 4; c++) begin
			seed = xs(seed);
			v = (c == 1) ? 8'h06 : (c == 2) ? 8'h07 : seed[7:0];
			amp_host_i.wr_reg(`AMP_OFS_VOL_BASE + 8'(c), v);
			rd_check(`AMP_OFS_VOL_BASE + 8'(c), v);
			check_port({24'h0, v}, {24'h0, ch_gain[31 - 8 * c -: 8]});
			check_port({31'h0, v < 8'h07}, {31'h0, ch_muted[3 - c]});
		end
		amp_host_i.wr_reg(`AMP_OFS_CTL, 8'hFF);
		rd_check(`AMP_OFS_CTL, 8'hE3);
		amp_host_i.wr_reg(`AMP_OFS_RPT12, 8'hFF);
		rd_check(`AMP_OFS_RPT12, 8'h00);
		amp_host_i.wr_reg(`AMP_OFS_THR12, 8'hA3);
		rd_check(`AMP_OFS_THR12, 8'hA3);
		// skip mode: leaving high impedance starts nothing, request 11 does
		amp_host_i.wr_reg(`AMP_OFS_CTL, 8'h41);
		snap();
		amp_host_i.wr_reg(`AMP_OFS_STATE, 8'h00);
		check_port(n0, runs);
		amp_host_i.wr_reg(`AMP_OFS_STATE, 8'hC0);
		check_port(32'h000000C0, {24'h0, ch_state});
		wait_idle();
		check_port(2 * RCYC, ramp_n - r0);
		check_port(SCYC, settle_n - s0);
		check_port(0, line_n - l0);
		check_port(1, runs - n0);
		rd_check(`AMP_OFS_RPT12, 8'hA0);
		rd_check(`AMP_OFS_STREP, 8'h40);
		// automatic run on leaving high impedance, line check on
		amp_host_i.wr_reg(`AMP_OFS_STATE, 8'h55);
		amp_host_i.wr_reg(`AMP_OFS_CTL, 8'h22);
		snap();
		amp_host_i.wr_reg(`AMP_OFS_STATE, 8'h09);
		wait_idle();
		check_port(RCYC, ramp_n - r0);
		check_port(2 * SCYC, settle_n - s0);
		check_port(LCYC, line_n - l0);
		check_port(1, runs - n0);
		rd_check(`AMP_OFS_RPT12, 8'hA4);
		rd_check(`AMP_OFS_RPT34, 8'h10);
		check_port(32'h00000009, {24'h0, ch_state});
		check_port(32'h1, {31'h0, ch_muted[1]});
		// a channel fault starts a run while not skipping
		snap();
		fault = 4'h1;
		repeat (10) @(negedge sys_clk);
		wait_idle();
		fault = 4'h0;
		check_port(1, runs - n0);
		// abort in mid-ramp: the aborted run leaves no result, no restart
		amp_host_i.wr_reg(`AMP_OFS_CTL, 8'h01);
		snap();
		amp_host_i.wr_reg(`AMP_OFS_STATE, 8'hC9);
		amp_host_i.wr_reg(`AMP_OFS_CTL, 8'h81);
		check_port(0, {31'h0, diag_ramp});
		check_port(0, {31'h0, ch_state[7:6] == 2'h3});
		rd_check(`AMP_OFS_RPT12, 8'h04);
		amp_host_i.wr_reg(`AMP_OFS_CTL, 8'h01);
		check_port(1, runs - n0);
		amp_host_i.wr_reg(`AMP_OFS_STATE, 8'hC9);
		wait_idle();
		check_port(2, runs - n0);
		// a fault in skip mode starts nothing
		fault = 4'h2;
		repeat (20) @(negedge sys_clk);
		check_port(2, runs - n0);
		check_port(0, nack_count);
		conclude();
	end
endmodule
